// *** src/smfoc_pkg.sv ***
// Package of constants and types for the scanner mode and field output controller
package smfoc_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned SCAN_US        = 66_667;   // One scan, 15 Hz
  localparam int unsigned SCAN_CYC       = (CLK_HZ / 1_000_000) * SCAN_US;
  localparam int unsigned BOOT_S         = 60;       // Least boot time in seconds
  localparam int unsigned BOOT_SCANS     = (BOOT_S * 1_000_000 + SCAN_US - 1) / SCAN_US;
  localparam int unsigned LOW_LIMIT_MS   = 67;       // Ready low limit for state four
  localparam int unsigned LOW_LIMIT_CYC  = LOW_LIMIT_MS * (CLK_HZ / 1_000);
  localparam int unsigned INDEX_US       = 1_000;    // Width of the index low pulse
  localparam int unsigned INDEX_CYC      = INDEX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CFG_LOW_SCANS  = 3;        // Ready low time after a configuring write
  localparam int unsigned STEPS_PER_SCAN = 811;      // 0.33 degree steps over 270 degrees
  localparam int unsigned INDEX_STEP     = 406;      // Step of the 90 degree beam
  localparam logic [3:0]  SET_DEFAULT    = 4'h0;     // Field set 1
  localparam logic        METHOD_WIRED   = 1'b0;
  localparam logic        METHOD_CMD     = 1'b1;
  // Delivery network settings
  localparam logic [31:0] NET_IP_DEF     = 32'hC0A80001;
  localparam logic [31:0] NET_MASK_DEF   = 32'hFFFFFF00;
  localparam logic [15:0] NET_PORT_DEF   = 16'h0840;

  typedef enum logic [2:0] {SMFOC_BOOT, SMFOC_READY, SMFOC_MONITOR, SMFOC_CONFIG, SMFOC_FAULT}
    smfoc_state_t;

  // Command port from the network side
  typedef struct packed {
    logic       wr_method;   // Write selection method
    logic       method;      // Method value
    logic       wr_set;      // Write active set
    logic [3:0] set_num;     // Set number, zero based
    logic       cfg_write;   // Configuring write happened
  } smfoc_cmd_t;

  // One distance sample
  typedef struct packed {
    logic        valid;
    logic [9:0]  step;
    logic [15:0] dist_mm;
  } smfoc_dist_t;
endpackage

// *** src/smfoc_top.sv ***
// Mode sequencer, field output driver and distance stream for the scanner
`timescale 1ns/1ps
module smfoc_top (
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  input  wire logic [3:0]         set_select_in,     // Wired set select pins
  input  wire logic [2:0]         field_hit_in,      // Per-field object flags from evaluator
  input  wire logic               fields_configured_in,
  input  wire logic               internal_error_in,
  input  wire logic               config_session_in, // Parameterization tool connected
  input  wire logic               service_login_in,  // Logged in user
  input  wire smfoc_pkg::smfoc_cmd_t cmd_in,
  input  wire logic [15:0]        dist_sample_in,    // Current beam distance
  output logic                    field_a_out_n,
  output logic                    field_b_out_n,
  output logic                    field_c_out_n,
  output logic                    ready_fault_out,
  output logic                    led_green_out,
  output logic                    led_red_out,
  output logic [3:0]              current_set_number_out,
  output logic                    set_choice_method_out,
  output logic [3:0]              eval_set_out,      // Set in use by the evaluator
  output smfoc_pkg::smfoc_dist_t  distance_output_message_out,
  output logic                    safe_state_out,
  output logic                    state3_out,
  output logic                    state4_out,
  output logic [31:0]             net_ip_out,
  output logic [31:0]             net_mask_out,
  output logic [15:0]             net_port_out
);
  import smfoc_pkg::*;

  smfoc_state_t state_q;                 // Operating state
  logic [22:0]  scan_cnt_q;              // Clock counter within a scan
  logic         tick_q;                  // One-cycle scan pulse
  logic [9:0]   boot_scans_q;            // Scans since supply start
  logic [3:0]   sel_m_q, sel_s_q;        // Pin synchroniser
  logic [2:0]   hit_m_q, hit_s_q;
  logic         err_m_q, err_s_q, cfg_m_q, cfg_s_q, log_m_q, log_s_q, fc_m_q, fc_s_q;
  logic         method_q;                // Set selection method
  logic [3:0]   cmd_set_q;               // Commanded set
  logic [3:0]   eval_set_q;              // Set applied to evaluation
  logic [2:0]   cfg_low_q;               // Scans left of configuring low
  logic [10:0]  step_q;                  // Beam step counter
  logic [15:0]  idx_cnt_q;               // Index low pulse timer
  logic [21:0]  low_cnt_q;               // Ready low duration counter
  logic         ready_base;              // Ready before index pulses
  logic         active;                  // Safety functions running

  // Two flip-flops on every pin-sourced input before use
  always_ff @(posedge mclk_in) begin
    sel_m_q <= set_select_in;
    sel_s_q <= sel_m_q;
    hit_m_q <= field_hit_in;
    hit_s_q <= hit_m_q;
    err_m_q <= internal_error_in;
    err_s_q <= err_m_q;
    cfg_m_q <= config_session_in;
    cfg_s_q <= cfg_m_q;
    log_m_q <= service_login_in;
    log_s_q <= log_m_q;
    fc_m_q  <= fields_configured_in;
    fc_s_q  <= fc_m_q;
  end

  // Scan tick; the boot, configuring-low and set-change limits below count in these ticks, the index and ready-low timers count clocks
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      scan_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (scan_cnt_q == 23'(SCAN_CYC - 1)) begin
      scan_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      scan_cnt_q <= scan_cnt_q + 23'h1;
      tick_q     <= 1'b0;
    end
  end

  // Boot scan counter saturates once the minute has passed
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      boot_scans_q <= '0;
    end else if (tick_q && boot_scans_q != 10'(BOOT_SCANS)) begin
      boot_scans_q <= boot_scans_q + 10'h1;
    end
  end

  // Operating state sequence; reset stands for supply start
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= SMFOC_BOOT;
    end else if (err_s_q) begin
      state_q <= SMFOC_FAULT;
    end else begin
      case (state_q)
        SMFOC_BOOT: begin
          state_q <= SMFOC_READY;
        end
        SMFOC_READY: begin
          // Readiness may not finish before one minute
          if (boot_scans_q == 10'(BOOT_SCANS)) begin
            state_q <= cfg_s_q ? SMFOC_CONFIG : SMFOC_MONITOR;
          end
        end
        SMFOC_MONITOR: begin
          if (cfg_s_q) begin
            state_q <= SMFOC_CONFIG;
          end
        end
        SMFOC_CONFIG: begin
          if (!cfg_s_q && cfg_low_q == 3'h0) begin
            state_q <= SMFOC_MONITOR;
          end
        end
        SMFOC_FAULT: begin
          state_q <= SMFOC_FAULT;  // Held until supply restart
        end
        default: begin
          state_q <= SMFOC_FAULT;
        end
      endcase
    end
  end

  // Configuring write pulls ready low for a few scans
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cfg_low_q <= '0;
    end else if (state_q == SMFOC_CONFIG && cmd_in.cfg_write) begin
      cfg_low_q <= 3'(CFG_LOW_SCANS);
    end else if (tick_q && cfg_low_q != 3'h0) begin
      cfg_low_q <= cfg_low_q - 3'h1;
    end
  end

  // Method and commanded set; method only changes with a login
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      method_q  <= METHOD_WIRED;
      cmd_set_q <= SET_DEFAULT;
    end else begin
      if (cmd_in.wr_method && log_s_q) begin
        method_q <= cmd_in.method;
      end
      if (cmd_in.wr_set) begin
        cmd_set_q <= cmd_in.set_num;
      end
    end
  end

  // New set taken at the next scan edge, within two scans
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      eval_set_q <= SET_DEFAULT;
    end else if (tick_q) begin
      eval_set_q <= (method_q == METHOD_CMD) ? cmd_set_q : sel_s_q;
    end
  end

  assign active = (state_q == SMFOC_MONITOR) && !log_s_q;

  // Field outputs: latched per scan so a hit drops them by the next tick
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      field_a_out_n <= 1'b0;
      field_b_out_n <= 1'b0;
      field_c_out_n <= 1'b0;
    end else if (!active || !fc_s_q) begin
      field_a_out_n <= 1'b0;
      field_b_out_n <= 1'b0;
      field_c_out_n <= 1'b0;
    end else if (tick_q) begin
      // Cascade: an inner field infringed also drops the outer outputs
      field_a_out_n <= !hit_s_q[0];
      field_b_out_n <= !(hit_s_q[0] | hit_s_q[1]);
      field_c_out_n <= !(|hit_s_q);
    end
  end

  // Beam step counter and distance stream, one value per step
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      step_q <= '0;
      distance_output_message_out <= '0;
    end else begin
      if (tick_q) begin
        step_q <= '0;
      end else if (step_q != 11'(STEPS_PER_SCAN)) begin
        step_q <= step_q + 11'h1;
      end
      distance_output_message_out.valid <= active && step_q < 11'(STEPS_PER_SCAN);
      distance_output_message_out.step  <= step_q[9:0];
      distance_output_message_out.dist_mm <= dist_sample_in;
    end
  end

  // Index pulse at the 90 degree beam, 15 Hz
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      idx_cnt_q <= '0;
    end else if (active && step_q == 11'(INDEX_STEP)) begin
      idx_cnt_q <= 16'(INDEX_CYC);
    end else if (idx_cnt_q != 16'h0) begin
      idx_cnt_q <= idx_cnt_q - 16'h1;
    end
  end

  // A write in the last config cycle must still pull ready low after the return to monitoring
  assign ready_base = (state_q == SMFOC_MONITOR || state_q == SMFOC_CONFIG) &&
                      cfg_low_q == 3'h0;

  // Ready output register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ready_fault_out <= 1'b0;
    end else begin
      ready_fault_out <= ready_base && idx_cnt_q == 16'h0;
    end
  end

  // Ready low duration; index pulses are far shorter than the limit
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      low_cnt_q <= '0;
    end else if (ready_fault_out) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != 22'(LOW_LIMIT_CYC)) begin
      low_cnt_q <= low_cnt_q + 22'h1;
    end
  end

  // Defined states and status registers
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state3_out <= 1'b0;
      state4_out <= 1'b0;
      safe_state_out <= 1'b1;
      led_green_out <= 1'b0;
      led_red_out <= 1'b0;
      current_set_number_out <= SET_DEFAULT;
      set_choice_method_out <= METHOD_WIRED;
      eval_set_out <= SET_DEFAULT;
      net_ip_out <= NET_IP_DEF;
      net_mask_out <= NET_MASK_DEF;
      net_port_out <= NET_PORT_DEF;
    end else begin
      state3_out <= (!field_a_out_n | !field_b_out_n | !field_c_out_n) && ~|hit_s_q;
      state4_out <= low_cnt_q == 22'(LOW_LIMIT_CYC);
      safe_state_out <= state3_out | state4_out | ~&{field_a_out_n, field_b_out_n,
                        field_c_out_n} | distance_output_message_out.valid;
      led_green_out <= state_q != SMFOC_FAULT && state_q != SMFOC_BOOT;
      // Bit 21 is the top bit the scan counter reaches, so red flashes once per scan
      led_red_out <= (state_q == SMFOC_FAULT) ? scan_cnt_q[21] : (active && |hit_s_q);
      current_set_number_out <= eval_set_q;
      set_choice_method_out <= method_q;
      eval_set_out <= eval_set_q;
      net_ip_out <= NET_IP_DEF;
      net_mask_out <= NET_MASK_DEF;
      net_port_out <= NET_PORT_DEF;
    end
  end

  // Checks
  property p_fault_ready_low;
    @(posedge mclk_in) disable iff (srst_in)
      state_q == SMFOC_FAULT |=> !ready_fault_out;
  endproperty
  a_fault_ready_low: assert property (p_fault_ready_low) else $error("ready high in fault");

  property p_login_safe;
    @(posedge mclk_in) disable iff (srst_in)
      log_s_q |=> !field_a_out_n && !field_b_out_n && !field_c_out_n;
  endproperty
  a_login_safe: assert property (p_login_safe) else $error("outputs free while logged in");

  property p_cascade;
    @(posedge mclk_in) disable iff (srst_in)
      !field_a_out_n |-> !field_b_out_n && !field_c_out_n;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade broken");

  property p_no_early_ready;
    @(posedge mclk_in) disable iff (srst_in)
      boot_scans_q != 10'(BOOT_SCANS) |-> state_q != SMFOC_MONITOR;
  endproperty
  a_no_early_ready: assert property (p_no_early_ready) else $error("monitor too early");

  property p_state4;
    @(posedge mclk_in) disable iff (srst_in)
      low_cnt_q == 22'(LOW_LIMIT_CYC) |=> state4_out;
  endproperty
  a_state4: assert property (p_state4) else $error("state four missed");

  property p_cfg_low;
    @(posedge mclk_in) disable iff (srst_in)
      state_q == SMFOC_CONFIG && cmd_in.cfg_write && !err_s_q |=> ##1 !ready_fault_out;
  endproperty
  a_cfg_low: assert property (p_cfg_low) else $error("ready not low after write");

  property p_method_login;
    @(posedge mclk_in) disable iff (srst_in)
      !log_s_q |=> method_q == $past(method_q);
  endproperty
  a_method_login: assert property (p_method_login) else $error("method changed no login");

  property p_no_data_idle;
    @(posedge mclk_in) disable iff (srst_in)
      !active |=> !distance_output_message_out.valid;
  endproperty
  a_no_data_idle: assert property (p_no_data_idle) else $error("data while inactive");

  c_monitor: cover property (@(posedge mclk_in) state_q == SMFOC_MONITOR);
  c_fault: cover property (@(posedge mclk_in) state_q == SMFOC_FAULT);
  c_hit: cover property (@(posedge mclk_in) !field_a_out_n && active);
endmodule

// *** test/smfoc_ctrl_model.sv ***
// Downstream controller model: issues set commands, polls the set and judges safety
`timescale 1ns/1ps
module smfoc_ctrl_model #(
  parameter int POLL_GAP_CYC = 60,  // Shortened stand-in for 134 ms
  parameter int SET_GAP_CYC  = 400  // Shortened stand-in for one second
) (
  input  wire logic            mclk_in,
  input  wire logic            field_a_in_n,
  input  wire logic            field_b_in_n,
  input  wire logic            field_c_in_n,
  input  wire logic            ready_fault_in,
  input  wire logic [3:0]      set_number_in,
  output smfoc_pkg::smfoc_cmd_t cmd_out,
  output logic                 safe_seen_out
);
  import smfoc_pkg::*;
  int cyc_cnt;        // Free running cycle count
  int last_set_cyc;   // Cycle of the last set change
  int last_poll_cyc;  // Cycle of the last readback
  initial begin
    cmd_out = '0;
    cyc_cnt = 0;
    last_set_cyc = -SET_GAP_CYC;
    last_poll_cyc = -POLL_GAP_CYC;
  end
  // Cycle count for spacing
  always @(posedge mclk_in) begin
    cyc_cnt <= cyc_cnt + 1;
  end
  // Any dropped output means the machine must be held safe
  assign safe_seen_out = !(field_a_in_n && field_b_in_n && field_c_in_n) || !ready_fault_in;
  // One command pulse; set changes wait out the spacing so no change is rushed
  task automatic send(input smfoc_cmd_t c);
    while (c.wr_set && (cyc_cnt - last_set_cyc) < SET_GAP_CYC) begin
      @(posedge mclk_in);
    end
    @(negedge mclk_in);
    cmd_out = c;
    if (c.wr_set) begin
      last_set_cyc = cyc_cnt;
    end
    @(negedge mclk_in);
    cmd_out = '0;
  endtask
  // Readback of the active set, never faster than the polling limit
  task automatic poll(output logic [3:0] v);
    while ((cyc_cnt - last_poll_cyc) < POLL_GAP_CYC) begin
      @(posedge mclk_in);
    end
    @(negedge mclk_in);
    v = set_number_in;
    last_poll_cyc = cyc_cnt;
  endtask
endmodule

// *** test/tb_smfoc_top.sv ***
// Self-checking bench for the scanner mode and field output controller
`timescale 1ns/1ps
module tb_smfoc_top;
  import smfoc_pkg::*;
  logic        mclk_in;
  logic        srst_in;
  logic [3:0]  set_select_in;
  logic [2:0]  field_hit_in;
  logic        fields_configured_in;
  logic        internal_error_in;
  logic        config_session_in;
  logic        service_login_in;
  smfoc_cmd_t  cmd_in;
  logic [15:0] dist_sample_in;
  logic        field_a_out_n;
  logic        field_b_out_n;
  logic        field_c_out_n;
  logic        ready_fault_out;
  logic        led_green_out;
  logic        led_red_out;
  logic [3:0]  current_set_number_out;
  logic        set_choice_method_out;
  logic [3:0]  eval_set_out;
  smfoc_dist_t distance_output_message_out;
  logic        safe_state_out;
  logic        state3_out;
  logic        state4_out;
  logic [31:0] net_ip_out;
  logic [31:0] net_mask_out;
  logic [15:0] net_port_out;
  logic        safe_seen;      // Controller's own judgement
  logic [3:0]  polled;         // Set number read back by the controller
  smfoc_cmd_t  c;              // Command under construction
  int          n_mismatch = 0;
  int          samples_checked = 0;

  smfoc_top uut (.mclk_in(mclk_in), .srst_in(srst_in), .set_select_in(set_select_in),
    .field_hit_in(field_hit_in), .fields_configured_in(fields_configured_in),
    .internal_error_in(internal_error_in), .config_session_in(config_session_in),
    .service_login_in(service_login_in), .cmd_in(cmd_in), .dist_sample_in(dist_sample_in),
    .field_a_out_n(field_a_out_n), .field_b_out_n(field_b_out_n),
    .field_c_out_n(field_c_out_n), .ready_fault_out(ready_fault_out),
    .led_green_out(led_green_out), .led_red_out(led_red_out),
    .current_set_number_out(current_set_number_out),
    .set_choice_method_out(set_choice_method_out), .eval_set_out(eval_set_out),
    .distance_output_message_out(distance_output_message_out),
    .safe_state_out(safe_state_out), .state3_out(state3_out), .state4_out(state4_out),
    .net_ip_out(net_ip_out), .net_mask_out(net_mask_out), .net_port_out(net_port_out));

  smfoc_ctrl_model #(.POLL_GAP_CYC(60), .SET_GAP_CYC(400)) u_ctrl (.mclk_in(mclk_in),
    .field_a_in_n(field_a_out_n), .field_b_in_n(field_b_out_n),
    .field_c_in_n(field_c_out_n), .ready_fault_in(ready_fault_out),
    .set_number_in(current_set_number_out), .cmd_out(cmd_in), .safe_seen_out(safe_seen));

  // 40 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  // One comparison; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reset held 8 cycles; outputs must already sit infringed
  task automatic do_reset();
    @(negedge mclk_in);
    srst_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    chk("reset outputs", 32'h0, {field_a_out_n, field_b_out_n, field_c_out_n});
    chk("reset safe", 32'h1, safe_state_out);
    srst_in = 1'b0;
  endtask

  // Boot lasts far beyond this run, so outputs and ready must stay low throughout
  task automatic hold_safe(input int n);
    repeat (n) begin
      @(negedge mclk_in);
      chk("distance", {16'h0, dist_sample_in}, {16'h0, distance_output_message_out.dist_mm});
      chk("data valid", 32'h0, distance_output_message_out.valid);
      dist_sample_in = dist_sample_in + 16'h0101;
      chk("outs", 32'h0, {field_a_out_n, field_b_out_n, field_c_out_n, ready_fault_out});
      chk("safe state", 32'h1, safe_state_out);
      chk("controller view", 32'h1, safe_seen);
    end
  endtask

  // Every field pattern during boot, with fields configured for the odd patterns only
  task automatic t_boot();
    for (int h = 0; h < 8; h++) begin
      @(negedge mclk_in);
      field_hit_in = h[2:0];
      fields_configured_in = h[0];
      hold_safe(150);
      chk("state three", (h == 0) ? 32'h1 : 32'h0, state3_out);
      chk("state four", 32'h0, state4_out);
      chk("green in readiness", 32'h1, led_green_out);
    end
  endtask

  // Delivery network settings and default selection
  task automatic t_defaults();
    chk("ip", {8'hC0, 8'hA8, 8'h00, 8'h01}, net_ip_out);
    chk("mask", 32'hFFFFFF00, net_mask_out);
    chk("port", 32'h00000840, {16'h0, net_port_out});
    chk("method", {31'h0, METHOD_WIRED}, set_choice_method_out);
    chk("set number", 32'h0, current_set_number_out);
    chk("eval set", 32'h0, eval_set_out);
  endtask

  // Set command in wired mode must not take effect
  task automatic t_set_wired();
    c = '0;
    c.wr_set = 1'b1;
    c.set_num = 4'h9;
    u_ctrl.send(c);
    repeat (20) @(negedge mclk_in);
    u_ctrl.poll(polled);
    chk("wired set readback", 32'h0, polled);
    chk("wired eval set", 32'h0, eval_set_out);
  endtask

  // Method write refused without login, taken with it; login keeps outputs safe
  task automatic t_method();
    c = '0;
    c.wr_method = 1'b1;
    c.method = METHOD_CMD;
    u_ctrl.send(c);
    repeat (10) @(negedge mclk_in);
    chk("method without login", {31'h0, METHOD_WIRED}, set_choice_method_out);
    service_login_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    u_ctrl.send(c);
    for (int i = 0; i < 10 && set_choice_method_out !== METHOD_CMD; i++) begin
      @(negedge mclk_in);
    end
    chk("method with login", {31'h0, METHOD_CMD}, set_choice_method_out);
    chk("data while logged in", 32'h0, distance_output_message_out.valid);
    c = '0;
    c.wr_set = 1'b1;
    c.set_num = 4'h5;
    u_ctrl.send(c);
    set_select_in = 4'h3;
    hold_safe(100);
    chk("data while logged in", 32'h0, distance_output_message_out.valid);
  endtask

  // Configuring write, then an internal error that latches until reset
  task automatic t_fault();
    config_session_in = 1'b1;
    c = '0;
    c.cfg_write = 1'b1;
    u_ctrl.send(c);
    hold_safe(50);
    internal_error_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    internal_error_in = 1'b0;
    config_session_in = 1'b0;
    service_login_in = 1'b0;
    hold_safe(200);
    chk("green in fault", 32'h0, led_green_out);
    do_reset();
    hold_safe(50);
    chk("green after reset", 32'h1, led_green_out);
    chk("method after reset", {31'h0, METHOD_WIRED}, set_choice_method_out);
  endtask

  // Main sequence
  initial begin
    srst_in = 1'b1;
    set_select_in = 4'h0;
    field_hit_in = 3'h0;
    fields_configured_in = 1'b0;
    internal_error_in = 1'b0;
    config_session_in = 1'b0;
    service_login_in = 1'b0;
    dist_sample_in = 16'h0000;
    do_reset();
    t_defaults();
    t_boot();
    t_set_wired();
    t_method();
    t_fault();
    summarize();
  end

  // Watchdog: the sequence needs some 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    $display("[FAIL] watchdog expected done seen hang");
    summarize();
  end
endmodule
